/* File: logic/mrmac_port.sv */
`timescale 1ns/1ps
`default_nettype none
module mrmac_port
  import mrmac_pkg::*;
#(
  parameter logic [CNT_W-1:0] DIV_100 = DIV_FAST,
  parameter logic [CNT_W-1:0] DIV_10  = DIV_SLOW
) (
  // clock and reset
  input  wire logic             clock_i,
  input  wire logic             nrst_i,
  // static configuration
  input  wire logic             rmii_mode_i,
  input  wire logic             dce_mode_i,
  input  wire logic             speed100_i,
  // user transmit nibbles, preamble included
  input  wire logic [MII_W-1:0] tx_data_i,
  input  wire logic             tx_valid_i,
  output logic                  tx_ready_o,
  // user receive nibbles
  output logic      [MII_W-1:0] rx_data_o,
  output logic                  rx_valid_o,
  output logic                  rx_error_o,
  // link clocks
  input  wire logic             ref_clk_i,
  input  wire logic             tx_clk_i,
  output logic                  tx_clk_o,
  output logic                  tx_clk_oe_o,
  input  wire logic             rx_clk_i,
  output logic                  rx_clk_o,
  output logic                  rx_clk_oe_o,
  // link transmit
  output logic      [MII_W-1:0] txd_o,
  output logic                  tx_en_o,
  // link receive
  input  wire logic [MII_W-1:0] rxd_i,
  input  wire logic             rx_dv_i,
  input  wire logic             crs_dv_i,
  input  wire logic             rx_err_i
);

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  // pins are oversampled at 200 MHz; the ~15 ns sync latency leaves
  // a 50 MHz ref clock little margin, the trade for one clock domain
  logic [CK_N-1:0] ck_q;
  logic [CK_N-1:0] ck_rise;
  logic [RP_N-1:0] rp_q;

  mrmac_sync #(.W(CK_N)) u_ck_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     ({rx_clk_i, tx_clk_i, ref_clk_i}),
    .q_o     (ck_q),
    .rise_o  (ck_rise)
  );

  mrmac_sync #(.W(RP_N)) u_rp_sync (
    .clock_i (clock_i),
    .nrst_i  (nrst_i),
    .d_i     ({rx_err_i, crs_dv_i, rx_dv_i, rxd_i}),
    .q_o     (rp_q),
    .rise_o  ()
  );

  // -----------------------------------------------------------------
  // dce clock generation from ref clock
  // -----------------------------------------------------------------
  logic [CNT_W-1:0] gen_cnt_reg;
  logic [CNT_W-1:0] gen_cnt_next;
  logic             gen_clk_reg;
  logic             gen_clk_next;
  logic             oe_reg;
  logic [CNT_W-1:0] gen_div;
  logic             gen_wrap;
  logic             gen_rise;

  assign gen_div      = speed100_i ? DIV_100 : DIV_10;
  assign gen_wrap     = ck_rise[CK_REF] && (gen_cnt_reg >= gen_div - 4'h1);
  assign gen_rise     = gen_wrap && !gen_clk_reg;
  assign gen_cnt_next = !ck_rise[CK_REF] ? gen_cnt_reg :
                        gen_wrap ? '0 : gen_cnt_reg + 4'h1;
  assign gen_clk_next = gen_wrap ? !gen_clk_reg : gen_clk_reg;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gen_cnt_reg <= '0;
      gen_clk_reg <= 1'b0;
      oe_reg      <= 1'b0;
    end
    else
    begin
      gen_cnt_reg <= gen_cnt_next;
      gen_clk_reg <= gen_clk_next;
      // drive clocks only in dce mii
      oe_reg      <= dce_mode_i && !rmii_mode_i;
    end
  end

  assign tx_clk_o    = gen_clk_reg;
  assign tx_clk_oe_o = oe_reg;
  assign rx_clk_o    = gen_clk_reg;
  assign rx_clk_oe_o = oe_reg;

  // -----------------------------------------------------------------
  // link ticks
  // -----------------------------------------------------------------
  logic [CNT_W-1:0] rm_cnt_reg;
  logic [CNT_W-1:0] rm_cnt_next;
  logic             rm_slot;
  logic             rm_tick;
  logic             mii_tx_tick;
  logic             mii_rx_tick;
  logic             tx_tick;
  logic             rx_tick;

  // one sample per ten ref periods at 10 Mbps, every ref period at 100 Mbps
  assign rm_slot     = speed100_i || (rm_cnt_reg == '0);
  assign rm_cnt_next = !ck_rise[CK_REF] ? rm_cnt_reg :
                       (rm_cnt_reg >= RMII_SLOW - 4'h1) ? '0 :
                       rm_cnt_reg + 4'h1;
  // rmii timed by ref clock alone
  assign rm_tick     = ck_rise[CK_REF] && rm_slot;
  assign mii_tx_tick = dce_mode_i ? gen_rise : ck_rise[CK_TX];
  assign mii_rx_tick = dce_mode_i ? gen_rise : ck_rise[CK_RX];
  assign tx_tick     = rmii_mode_i ? rm_tick : mii_tx_tick;
  assign rx_tick     = rmii_mode_i ? rm_tick : mii_rx_tick;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rm_cnt_reg <= '0;
    else
      rm_cnt_reg <= rm_cnt_next;
  end

  // -----------------------------------------------------------------
  // transmit
  // -----------------------------------------------------------------
  logic [MII_W-1:0] txd_reg;
  logic [MII_W-1:0] txd_next;
  logic             tx_en_reg;
  logic             tx_en_next;
  logic             tx_half_reg;
  logic             tx_half_next;
  logic [1:0]       tx_hi_reg;
  logic [1:0]       tx_hi_next;
  logic             tx_take;
  logic             tx_hold;

  // second dibit of an rmii nibble still owed
  assign tx_hold      = rmii_mode_i && tx_half_reg;
  assign tx_take      = tx_tick && !tx_hold && tx_valid_i;
  // no gap while nibbles keep coming
  assign tx_en_next   = !tx_tick ? tx_en_reg : (tx_hold || tx_valid_i);
  // bit 0 lsb, idle data zero
  assign txd_next     = !tx_tick ? txd_reg :
                        tx_hold ? {2'h0, tx_hi_reg} :
                        !tx_valid_i ? '0 :
                        rmii_mode_i ? {2'h0, tx_data_i[1:0]} : tx_data_i;
  assign tx_half_next = !tx_tick ? tx_half_reg : (tx_take && rmii_mode_i);
  assign tx_hi_next   = tx_take ? tx_data_i[3:2] : tx_hi_reg;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      txd_reg     <= '0;
      tx_en_reg   <= 1'b0;
      tx_half_reg <= 1'b0;
      tx_hi_reg   <= '0;
      tx_ready_o  <= 1'b0;
    end
    else
    begin
      txd_reg     <= txd_next;
      tx_en_reg   <= tx_en_next;
      tx_half_reg <= tx_half_next;
      tx_hi_reg   <= tx_hi_next;
      tx_ready_o  <= tx_take;
    end
  end

  assign txd_o   = txd_reg;
  assign tx_en_o = tx_en_reg;

  // -----------------------------------------------------------------
  // receive
  // -----------------------------------------------------------------
  logic             rx_dv;
  logic             rx_low_reg;
  logic             rx_low_next;
  logic [1:0]       rx_lo_reg;
  logic [1:0]       rx_lo_next;
  logic             rx_out;
  logic [MII_W-1:0] rx_word;

  assign rx_dv       = rmii_mode_i ? rp_q[RP_CRS] : rp_q[RP_DV];
  // rx error only seen, not checked
  assign rx_out      = rx_tick && rx_dv && (!rmii_mode_i || rx_low_reg);
  assign rx_word     = rmii_mode_i ? {rp_q[1:0], rx_lo_reg} : rp_q[3:0];
  // an odd dibit at frame end is dropped
  assign rx_low_next = !rx_tick ? rx_low_reg :
                       (rx_dv && rmii_mode_i && !rx_low_reg);
  assign rx_lo_next  = (rx_tick && rx_dv && !rx_low_reg) ? rp_q[1:0]
                                                         : rx_lo_reg;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      rx_low_reg <= 1'b0;
      rx_lo_reg  <= '0;
      rx_data_o  <= '0;
      rx_valid_o <= 1'b0;
      rx_error_o <= 1'b0;
    end
    else
    begin
      rx_low_reg <= rx_low_next;
      rx_lo_reg  <= rx_lo_next;
      rx_valid_o <= rx_out;
      if (rx_out)
      begin
        rx_data_o  <= rx_word;
        rx_error_o <= rp_q[RP_ERR];
      end
    end
  end

endmodule : mrmac_port
`default_nettype wire

/* File: logic/mrmac_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module mrmac_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         clock_i,
  input  wire logic         nrst_i,
  // pins
  input  wire logic [W-1:0] d_i,
  // synchronised level and rising edge
  output logic      [W-1:0] q_o,
  output logic      [W-1:0] rise_o
);

  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;
  logic [W-1:0] prev_reg;

  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_reg <= '0;
      sync_reg <= '0;
      prev_reg <= '0;
    end
    else
    begin
      meta_reg <= d_i;
      sync_reg <= meta_reg;
      prev_reg <= sync_reg;
    end
  end

  // edge taken on the second stage only, never on meta_reg
  assign q_o    = sync_reg;
  assign rise_o = sync_reg & ~prev_reg;

endmodule : mrmac_sync
`default_nettype wire

/* File: shared/mrmac_pkg.sv */
// Operation
// - mii: transmit enable rises with first preamble nibble, falls between frames
// - mii: enable and nibble change on rising tx clock, bit 0 lsb
// - rmii: dibit presented per ref clock edge, valid only while enable high
// - mii receive clock is 25 MHz at 100 Mbps, 2.5 MHz at 10 Mbps
// - receive clock is input in dte, output derived from ref clock in dce
// - mii: sample nibble, data valid and error on each rising receive clock
// - mii: discard receive nibble whenever data valid is low
// - rmii 100 Mbps: take dibit per ref period while carrier/valid high
// - rmii 10 Mbps: sample receive dibit once every ten ref periods
// - rmii: all link signals timed by one ref clock up to 50 MHz
// - tx clock 25/2.5 MHz; input in dte, output from ref clock in dce
package mrmac_pkg;

  // -----------------------------------------------------------------
  // link and counter widths
  // -----------------------------------------------------------------
  localparam int unsigned MII_W     = 4;
  localparam int unsigned RMII_W    = 2;
  localparam int unsigned CNT_W     = 4;

  // -----------------------------------------------------------------
  // clock division counts (ref clock edges per generated half period)
  // -----------------------------------------------------------------
  localparam logic [CNT_W-1:0] DIV_FAST  = 4'h1;
  localparam logic [CNT_W-1:0] DIV_SLOW  = 4'hA;
  // ref periods per rmii sample at 10 Mbps
  localparam logic [CNT_W-1:0] RMII_SLOW = 4'hA;

  // -----------------------------------------------------------------
  // synchroniser bit positions for the clock pins
  // -----------------------------------------------------------------
  localparam int unsigned CK_REF = 0;
  localparam int unsigned CK_TX  = 1;
  localparam int unsigned CK_RX  = 2;
  localparam int unsigned CK_N   = 3;
  // receive pin group: rxd[3:0], rx_dv, crs_dv, rx_err
  localparam int unsigned RP_DV  = 4;
  localparam int unsigned RP_CRS = 5;
  localparam int unsigned RP_ERR = 6;
  localparam int unsigned RP_N   = 7;

endpackage : mrmac_pkg

/* File: tb/mrmac_phy.sv */
`timescale 1ns/1ps
`default_nettype none
module mrmac_phy
  import mrmac_pkg::*;
(
  // mode
  input  wire logic             rmii_i,
  input  wire logic             fast_i,
  // device transmit pins
  input  wire logic [MII_W-1:0] txd_i,
  input  wire logic             tx_en_i,
  // clocks and receive pins
  output logic                  ref_clk_o,
  output logic                  tx_clk_o,
  output logic                  rx_clk_o,
  output logic      [MII_W-1:0] rxd_o,
  output logic                  rx_dv_o,
  output logic                  crs_dv_o,
  output logic                  rx_err_o
);
  logic [MII_W-1:0] txq[$];
  logic [1:0]       lo;
  logic             half;
  int               sk;
  initial
  begin
    {ref_clk_o, rxd_o, rx_dv_o, crs_dv_o, rx_err_o, half} = '0;
    forever #10 ref_clk_o = ~ref_clk_o;
  end
  // mii clocks 25 or 2.5 MHz
  // speed is unknown at time zero, so the slow period is the fallback
  initial
  begin
    tx_clk_o = 1'b0;
    forever #(fast_i === 1'b1 ? 20 : 200) tx_clk_o = ~tx_clk_o;
  end
  assign rx_clk_o = ~tx_clk_o;
  task automatic send(input logic [5:0] q[$]);
    foreach (q[i])
      for (int h = 0; h < (rmii_i ? 2 : 1); h++)
        for (int r = 0; r < (rmii_i && !fast_i ? 10 : 1); r++)
        begin
          @(negedge (rmii_i ? ref_clk_o : rx_clk_o));
          rxd_o = rmii_i ? {~rxd_o[3:2], q[i][2*h+:2]} : q[i][3:0];
          rx_err_o = q[i][4];
          rx_dv_o = q[i][5] && !rmii_i;
          crs_dv_o = q[i][5];
        end
    @(negedge (rmii_i ? ref_clk_o : rx_clk_o));
    // released data must not look like the last nibble
    rxd_o = ~rxd_o;
    {rx_dv_o, crs_dv_o} = 2'h0;
  endtask : send
  always @(posedge tx_clk_o)
    if (!rmii_i && tx_en_i)
      txq.push_back(txd_i);
  // dibit low half first
  // sampled mid period since device output lags the ref edge
  // at 10 Mbps a dibit stands ten ref periods, so take every tenth
  always @(negedge ref_clk_o)
  begin
    sk = (fast_i || sk >= 9) ? 0 : sk + 1;
    if (sk == 0)
    begin
      if (rmii_i && tx_en_i && half)
        txq.push_back({txd_i[1:0], lo});
      lo = txd_i[1:0];
      half = rmii_i && tx_en_i && !half;
    end
  end
endmodule : mrmac_phy
`default_nettype wire

/* File: tb/mrmac_port_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mrmac_port_chk
  import mrmac_pkg::*;
(
  // watched ports
  input wire logic             clock_i,
  input wire logic             nrst_i,
  input wire logic             rmii_mode_i,
  input wire logic             dce_mode_i,
  input wire logic             tx_valid_i,
  input wire logic             tx_ready_o,
  input wire logic [MII_W-1:0] txd_o,
  input wire logic             tx_en_o,
  input wire logic             tx_clk_o,
  input wire logic             tx_clk_oe_o,
  input wire logic             rx_clk_o,
  input wire logic             rx_clk_oe_o,
  input wire logic [MII_W-1:0] rx_data_o,
  input wire logic             rx_valid_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!nrst_i);

  AST_RDY_PULSE: assert property (tx_ready_o |=> !tx_ready_o)
    else $error("tx ready wider than one cycle");
  AST_RDY_EN: assert property (tx_ready_o |-> tx_en_o)
    else $error("nibble taken with enable low");
  AST_EN_GAP: assert property ($fell(tx_en_o) |-> !$past(tx_valid_i))
    else $error("enable dropped inside a frame");
  AST_IDLE_ZERO: assert property (!tx_en_o |-> txd_o == 4'h0)
    else $error("data driven while enable low");
  AST_RMII_HI: assert property (rmii_mode_i |-> txd_o[3:2] == 2'h0)
    else $error("upper data bits driven in rmii");
  AST_TXD_STEP: assert property (
    !rmii_mode_i && tx_en_o && $past(tx_en_o) && $changed(txd_o)
    |-> tx_ready_o) else $error("nibble changed without a take");
  AST_OE: assert property ($past(nrst_i) |->
    tx_clk_oe_o == (dce_mode_i && !rmii_mode_i) && rx_clk_oe_o == tx_clk_oe_o)
    else $error("clock enable wrong for mode");
  AST_CLK_HALF: assert property ($changed(tx_clk_o) |=> $stable(tx_clk_o)[*3])
    else $error("generated clock half period too short");
  AST_RXV_PULSE: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("rx valid wider than one cycle");
  AST_RX_HOLD: assert property (
    !rx_valid_o && $past(nrst_i) |-> $stable(rx_data_o))
    else $error("rx data moved without valid");
endmodule : mrmac_port_chk
`default_nettype wire

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mrmac_pkg::*;
  logic       clock_i, nrst, rmii, dce, fast, tx_valid, tx_ready, tx_en;
  logic       rx_valid, rx_error, ref_clk, ptx_clk, prx_clk, tx_clk, rx_clk;
  logic       tx_oe, rx_oe, rx_dv, crs_dv, rx_err;
  logic [3:0] tx_data, rx_data, txd, rxd, exq[$];
  logic [4:0] rxq[$];
  int         bad_count, checked;
  realtime    t0;
  wire        txc = tx_oe ? tx_clk : ptx_clk;
  wire        rxc = rx_oe ? rx_clk : prx_clk;

  mrmac_port dut (.clock_i(clock_i), .nrst_i(nrst), .rmii_mode_i(rmii),
    .dce_mode_i(dce), .speed100_i(fast), .tx_data_i(tx_data),
    .tx_valid_i(tx_valid), .tx_ready_o(tx_ready), .rx_data_o(rx_data),
    .rx_valid_o(rx_valid), .rx_error_o(rx_error), .ref_clk_i(ref_clk),
    .tx_clk_i(txc), .tx_clk_o(tx_clk), .tx_clk_oe_o(tx_oe), .rx_clk_i(rxc),
    .rx_clk_o(rx_clk), .rx_clk_oe_o(rx_oe), .txd_o(txd), .tx_en_o(tx_en),
    .rxd_i(rxd), .rx_dv_i(rx_dv), .crs_dv_i(crs_dv), .rx_err_i(rx_err));
  mrmac_phy phy (.rmii_i(rmii), .fast_i(fast), .txd_i(txd), .tx_en_i(tx_en),
    .ref_clk_o(ref_clk), .tx_clk_o(ptx_clk), .rx_clk_o(prx_clk),
    .rxd_o(rxd), .rx_dv_o(rx_dv), .crs_dv_o(crs_dv), .rx_err_o(rx_err));

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask : check
  task automatic conclude;
    $display("checks %0d errors %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic start(input logic d, input logic r, input logic f);
    @(posedge clock_i);
    #1 nrst = 0;
    {dce, rmii, fast} = {d, r, f};
    repeat (6) @(posedge clock_i);
    #1 nrst = 1;
    repeat (10) @(posedge clock_i);
  endtask : start
  task automatic rx_frame;
    logic [5:0] q[$];
    logic [5:0] v;
    for (int i = 0; i < 10; i++)
    begin
      v = {i != 4, 5'($urandom)};
      q.push_back(v);
      if (v[5])
        rxq.push_back(v[4:0]);
    end
    phy.send(q);
    repeat (20) @(posedge clock_i);
    check(16'(rxq.size()), 16'h0);
  endtask : rx_frame
  task automatic tx_frame;
    int w;
    #1 phy.txq.delete();
    exq.delete();
    for (int i = 0; i < 6; i++)
    begin
      tx_valid = 1;
      tx_data = 4'($urandom);
      exq.push_back(tx_data);
      w = 0;
      do
      begin
        @(posedge clock_i);
        #1 w++;
      end
      while (tx_ready !== 1'b1 && w < 999);
    end
    tx_valid = 0;
    repeat (300) @(posedge clock_i);
    check(16'(phy.txq.size()), 16'h6);
    while (phy.txq.size() > 0 && exq.size() > 0)
      check(16'(phy.txq.pop_front()), 16'(exq.pop_front()));
  endtask : tx_frame

  always @(negedge clock_i)
    if (rx_valid === 1'b1)
    begin
      check(16'(rxq.size() > 0), 16'h1);
      if (rxq.size() > 0)
        check(16'({rx_error, rx_data}), 16'(rxq.pop_front()));
    end
  initial
  begin
    clock_i = 0;
    forever #2.5 clock_i = ~clock_i;
  end
  // all modes need about 25 us together, so this only trips on a hang
  initial
  begin
    #100us;
    bad_count++;
    conclude();
  end
  initial
  begin
    {nrst, rmii, dce, fast, tx_valid, tx_data} = '0;
    bad_count = 0;
    checked = 0;
    void'($urandom(32'h6f7e4260));
    for (int m = 0; m < 6; m++)
    begin
      start(m > 3, m[1], m[0]);
      if (m > 3)
      begin
        repeat (2) @(posedge tx_clk);
        t0 = $realtime;
        @(posedge tx_clk);
        check(16'($rtoi($realtime - t0)), fast ? 16'h28 : 16'h190);
        @(posedge rx_clk);
        t0 = $realtime;
        @(posedge rx_clk);
        check(16'($rtoi($realtime - t0)), fast ? 16'h28 : 16'h190);
      end
      else
      begin
        rx_frame();
        tx_frame();
      end
    end
    conclude();
  end
endmodule : tb_top
bind mrmac_port mrmac_port_chk chk (.clock_i(clock_i), .nrst_i(nrst_i),
  .rmii_mode_i(rmii_mode_i), .dce_mode_i(dce_mode_i),
  .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .txd_o(txd_o),
  .tx_en_o(tx_en_o), .tx_clk_o(tx_clk_o), .tx_clk_oe_o(tx_clk_oe_o),
  .rx_clk_o(rx_clk_o), .rx_clk_oe_o(rx_clk_oe_o), .rx_data_o(rx_data_o),
  .rx_valid_o(rx_valid_o));
`default_nettype wire
